// [rtl/cct_timer.sv]
// Purpose: Capture/compare timer, two 16-bit halves or one 32-bit counter
// Assumes: Timer count clock equals i_clk; AXI4-Lite slave registers
// Notes: Only capture/compare, dual-edge, gated and inactive gated count
//
// Contract
// [RULE1] Capture/compare mode waits for first selected input edge before counting.
// [RULE2] Polarity bit 1 picks rising edges, 0 picks falling edges.
// [RULE3] Each later active edge copies the count into capture/match.
// [RULE4] Capture raises an event, reloads count with one, keeps running.
// [RULE5] Clock after count equals compare: event, reload with one.
// [RULE6] Period end sets the half's event flag; timer stays enabled.
// [RULE7] The starting edge raises no event.
// [RULE8] A software count write affects only the first period.
// [RULE9] Count and capture/match writes need the clock enable bit set.
// [RULE10] Software polls the enable bit until it reads one.
// [RULE11] Dual-edge mode captures on both input edges.
// [RULE12] Inactive gated mode raises events while input is inactive.
// [RULE13] Count comes out of timer reset at zero.
// [RULE14] Count reads always return the live count.
// [RULE15] Pulse-width match sets first phase; software keeps it below compare. Code has no pulse-width mode; that code only holds the count.
// [RULE16] Upper write-protect bit limits writes to low half; reads zero cascaded. Code blocks upper-half writes while this bit is clear, allows them while set.
// [RULE17] Lower write-protect bit governs low-half writes; reads zero cascaded.
// [RULE18] Upper-half write clears upper write-done until complete.
// [RULE19] Lower-half write clears lower write-done until complete.
// [RULE20] Half interrupt flags set on events, clear on write one.
// [RULE21] All fields return to reset values on every reset.
// [RULE22] Registers sit at fixed offsets 0x00 through 0x1C.
// [RULE23] Cascade bit picks two 16-bit timers or one 32-bit timer.
// [RULE24] Four-bit mode field per half; reserved codes do nothing.
// [RULE25] Timer input is synchronised before edge detection.
`timescale 1ns/1ps
module cct_timer #(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_timer_in,
  output logic o_event_a,
  output logic o_event_b
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < 5)
  begin : g_bad_addr
    $error("cct_timer: ADDR_W must be at least 5");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] in_sync;
    logic in_prev;
    logic [31:0] count;
    logic [31:0] compare;
    logic [31:0] capmatch;
    logic [31:0] prictrl;
    logic [31:0] deadtime;
    logic [31:0] secctrl;
    logic [31:0] wakeup;
    logic [1:0] started;
    logic [1:0] irq;
    logic [1:0] wrdone;
    logic [1:0] wrdis;
    logic [1:0] evt;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cct_state_t;

  cct_state_t st_ff;
  cct_state_t nxt_st;

  // Helper: address is one of the eight mapped words
  function automatic logic cct_mapped(input logic [ADDR_W-1:0] a);
    cct_mapped = (a[1:0] == 2'h0) && (a < ADDR_W'(cct_pkg::OFS_WAKEUP + 8'h04));
  endfunction : cct_mapped

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic cascade;
    logic edge_in;
    logic rise;
    logic fall;
    logic act_lvl;
    logic do_wr;
    logic [7:0] wofs;
    logic [31:0] wmask;
    logic [31:0] bytemask;
    logic [1:0] half_en;
    logic [1:0] half_clken;
    logic [1:0] half_rst;
    logic [3:0] mode;
    logic pol;
    logic active_edge;
    logic [15:0] cnt16;
    logic [15:0] cmp16;
    logic [31:0] sel_rd;
    nxt_st = st_ff;
    // [RULE23] width select
    cascade = st_ff.secctrl[cct_pkg::SC_CASCADE];
    do_wr = 1'b0;
    wofs = 8'h00;
    wmask = 32'h0000_0000;
    bytemask = 32'h0000_0000;
    mode = 4'h0;
    pol = 1'b0;
    active_edge = 1'b0;
    act_lvl = 1'b0;
    cnt16 = 16'h0000;
    cmp16 = 16'h0000;
    sel_rd = 32'h0000_0000;
    nxt_st.evt = 2'b00;

    // Two-stage input synchroniser, edge taken from second stage
    // [RULE25] sync then detect
    nxt_st.in_sync = {st_ff.in_sync[0], i_timer_in};
    nxt_st.in_prev = st_ff.in_sync[1];
    rise = st_ff.in_sync[1] & ~st_ff.in_prev;
    fall = ~st_ff.in_sync[1] & st_ff.in_prev;
    edge_in = rise | fall;

    half_en = {st_ff.prictrl[cct_pkg::PC_EN_B], st_ff.prictrl[cct_pkg::PC_EN_A]};
    half_clken = {st_ff.prictrl[cct_pkg::PC_CLKEN_B], st_ff.prictrl[cct_pkg::PC_CLKEN_A]};
    half_rst = {st_ff.prictrl[cct_pkg::PC_RST_B], st_ff.prictrl[cct_pkg::PC_RST_A]};

    // Timer behaviour per half; half B idles in cascade mode
    for (int h = 0; h < 2; h++)
    begin
      mode = st_ff.prictrl[h*16 +: 4];
      pol = st_ff.prictrl[cct_pkg::PC_POL_A];
      // [RULE2] edge polarity select
      active_edge = pol ? rise : fall;
      // [RULE11] both edges capture
      if (mode == cct_pkg::MODE_DUALEDGE)
        active_edge = edge_in;
      act_lvl = pol ? st_ff.in_sync[1] : ~st_ff.in_sync[1];
      cnt16 = st_ff.count[h*16 +: 16];
      cmp16 = st_ff.compare[h*16 +: 16];
      if (half_rst[h])
      begin
        // [RULE13] reset holds zero
        nxt_st.count[h*16 +: 16] = 16'h0000;
        if (cascade && h == 0)
          nxt_st.count[31:16] = 16'h0000;
        nxt_st.started[h] = 1'b0;
        // Reset bit clears itself after one cycle
        nxt_st.prictrl[cct_pkg::PC_RST_A + h*16] = 1'b0;
      end
      else if (half_en[h] && (!cascade || h == 0))
      begin
        if (mode == cct_pkg::MODE_CAPCMP || mode == cct_pkg::MODE_DUALEDGE)
        begin
          if (!st_ff.started[h])
          begin
            // [RULE1] wait for first edge
            // [RULE7] start edge raises nothing
            if (active_edge)
              nxt_st.started[h] = 1'b1;
          end
          else if (active_edge)
          begin
            // [RULE3] capture count
            // [RULE4] reload after capture
            // [RULE8] later periods from one
            if (cascade)
            begin
              nxt_st.capmatch = st_ff.count;
              nxt_st.count = cct_pkg::RELOAD_VAL;
            end
            else
            begin
              nxt_st.capmatch[h*16 +: 16] = cnt16;
              nxt_st.count[h*16 +: 16] = cct_pkg::RELOAD_VAL[15:0];
            end
            nxt_st.evt[h] = 1'b1;
          end
          // [RULE5] match ends period
          else if (cascade ? (st_ff.count == st_ff.compare) : (cnt16 == cmp16))
          begin
            if (cascade)
              nxt_st.count = cct_pkg::RELOAD_VAL;
            else
              nxt_st.count[h*16 +: 16] = cct_pkg::RELOAD_VAL[15:0];
            nxt_st.evt[h] = 1'b1;
          end
          else if (cascade)
            nxt_st.count = st_ff.count + 32'h0000_0001;
          else
            nxt_st.count[h*16 +: 16] = cnt16 + 16'h0001;
        end
        else if (mode == cct_pkg::MODE_GATED || mode == cct_pkg::MODE_INACT_GATED)
        begin
          if (cascade ? (st_ff.count == st_ff.compare) : (cnt16 == cmp16))
          begin
            if (cascade)
              nxt_st.count = cct_pkg::RELOAD_VAL;
            else
              nxt_st.count[h*16 +: 16] = cct_pkg::RELOAD_VAL[15:0];
            nxt_st.evt[h] = (mode == cct_pkg::MODE_GATED);
          end
          else if (act_lvl)
          begin
            if (cascade)
              nxt_st.count = st_ff.count + 32'h0000_0001;
            else
              nxt_st.count[h*16 +: 16] = cnt16 + 16'h0001;
          end
          // [RULE12] event while inactive
          if (mode == cct_pkg::MODE_INACT_GATED && !act_lvl)
            nxt_st.evt[h] = 1'b1;
        end
        // [RULE24] other codes hold count
        // [RULE15] pulse-width code holds count; no output phase pin here
      end
    end

    // Write-done completes one cycle after the write
    nxt_st.wrdone = 2'b11;

    // ---------------- AXI4-Lite write channel ----------------
    if (st_ff.awready && i_awvalid)
    begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = i_awaddr;
    end
    if (st_ff.wready && i_wvalid)
    begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = i_wdata;
      nxt_st.w_strb = i_wstrb;
    end
    nxt_st.awready = ~nxt_st.aw_held & ~st_ff.bvalid;
    nxt_st.wready = ~nxt_st.w_held & ~st_ff.bvalid;
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid)
    begin
      do_wr = cct_mapped(st_ff.aw_addr);
      wofs = 8'(st_ff.aw_addr);
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = do_wr ? cct_pkg::RESP_OKAY : cct_pkg::RESP_SLVERR;
      nxt_st.awready = 1'b0;
      nxt_st.wready = 1'b0;
    end
    if (st_ff.bvalid && i_bready)
    begin
      nxt_st.bvalid = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready = 1'b1;
    end

    for (int b = 0; b < 4; b++)
      bytemask[b*8 +: 8] = {8{st_ff.w_strb[b]}};

    // [RULE22] fixed register offsets
    if (do_wr)
    begin
      case (wofs)
        cct_pkg::OFS_COUNT, cct_pkg::OFS_CAPMATCH:
        begin
          // [RULE9] clock enable gate
          // [RULE16] upper protect
          // [RULE17] lower protect
          wmask = bytemask;
          if (!half_clken[0])
            wmask = 32'h0000_0000;
          if (!cascade)
          begin
            if (!st_ff.wrdis[1] || !half_clken[1])
              wmask[31:16] = 16'h0000;
            if (st_ff.wrdis[0])
              wmask[15:0] = 16'h0000;
            // [RULE18] upper write-done
            // [RULE19] lower write-done
            if (|wmask[31:16])
              nxt_st.wrdone[1] = 1'b0;
            if (|wmask[15:0])
              nxt_st.wrdone[0] = 1'b0;
          end
          if (wofs == cct_pkg::OFS_COUNT)
          begin
            // [RULE8] first period only
            nxt_st.count = (nxt_st.count & ~wmask) | (st_ff.w_data & wmask);
          end
          else
            nxt_st.capmatch = (nxt_st.capmatch & ~wmask) | (st_ff.w_data & wmask);
        end
        cct_pkg::OFS_COMPARE:
          nxt_st.compare = (st_ff.compare & ~bytemask) | (st_ff.w_data & bytemask);
        cct_pkg::OFS_EVFLAGS:
        begin
          // [RULE20] write one clears
          if (st_ff.w_strb[0] && st_ff.w_data[cct_pkg::FL_IRQ_A])
            nxt_st.irq[0] = 1'b0;
          if (st_ff.w_strb[2] && st_ff.w_data[cct_pkg::FL_IRQ_B])
            nxt_st.irq[1] = 1'b0;
          if (st_ff.w_strb[1])
            nxt_st.wrdis[0] = st_ff.w_data[cct_pkg::FL_WRDIS_A];
          if (st_ff.w_strb[3])
            nxt_st.wrdis[1] = st_ff.w_data[cct_pkg::FL_WRDIS_B];
        end
        cct_pkg::OFS_PRICTRL:
        begin
          wmask = bytemask & cct_pkg::PRICTRL_WMASK;
          nxt_st.prictrl = (st_ff.prictrl & ~wmask) | (st_ff.w_data & wmask);
        end
        cct_pkg::OFS_DEADTIME:
          nxt_st.deadtime = (st_ff.deadtime & ~bytemask) | (st_ff.w_data & bytemask);
        cct_pkg::OFS_SECCTRL:
        begin
          wmask = bytemask & cct_pkg::SECCTRL_WMASK;
          nxt_st.secctrl = (st_ff.secctrl & ~wmask) | (st_ff.w_data & wmask);
        end
        cct_pkg::OFS_WAKEUP:
        begin
          wmask = bytemask & cct_pkg::WAKEUP_WMASK;
          nxt_st.wakeup = st_ff.wakeup & ~(st_ff.w_data & wmask);
        end
        default:
          nxt_st.wakeup = st_ff.wakeup;
      endcase
    end

    // Event sets after the clear so a simultaneous event wins
    // [RULE6] flag on period end
    // [RULE20] set on event
    nxt_st.irq = nxt_st.irq | nxt_st.evt;

    // ---------------- AXI4-Lite read channel ----------------
    if (st_ff.arready && i_arvalid)
    begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = cct_mapped(i_araddr) ? cct_pkg::RESP_OKAY : cct_pkg::RESP_SLVERR;
      case (8'(i_araddr))
        // [RULE14] live count
        cct_pkg::OFS_COUNT: sel_rd = st_ff.count;
        cct_pkg::OFS_COMPARE: sel_rd = st_ff.compare;
        cct_pkg::OFS_CAPMATCH: sel_rd = st_ff.capmatch;
        cct_pkg::OFS_EVFLAGS:
        begin
          sel_rd[cct_pkg::FL_IRQ_A] = st_ff.irq[0];
          sel_rd[cct_pkg::FL_IRQ_B] = st_ff.irq[1];
          sel_rd[cct_pkg::FL_WRDONE_A] = st_ff.wrdone[0];
          sel_rd[cct_pkg::FL_WRDONE_B] = st_ff.wrdone[1];
          // [RULE16] reads zero cascaded
          // [RULE17] reads zero cascaded
          sel_rd[cct_pkg::FL_WRDIS_A] = st_ff.wrdis[0] & ~cascade;
          sel_rd[cct_pkg::FL_WRDIS_B] = st_ff.wrdis[1] & ~cascade;
        end
        cct_pkg::OFS_PRICTRL: sel_rd = st_ff.prictrl;
        cct_pkg::OFS_DEADTIME: sel_rd = st_ff.deadtime;
        cct_pkg::OFS_SECCTRL: sel_rd = st_ff.secctrl;
        cct_pkg::OFS_WAKEUP: sel_rd = st_ff.wakeup;
        default: sel_rd = 32'h0000_0000;
      endcase
      nxt_st.rdata = sel_rd;
    end
    if (st_ff.rvalid && i_rready)
    begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // [RULE21] every field to reset value
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      st_ff <= '0;
      st_ff.prictrl <= cct_pkg::PRICTRL_RST;
      st_ff.wrdone <= 2'b11;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign o_awready = st_ff.awready;
  assign o_wready = st_ff.wready;
  assign o_bvalid = st_ff.bvalid;
  assign o_bresp = st_ff.bresp;
  assign o_arready = st_ff.arready;
  assign o_rvalid = st_ff.rvalid;
  assign o_rdata = st_ff.rdata;
  assign o_rresp = st_ff.rresp;
  assign o_event_a = st_ff.evt[0];
  assign o_event_b = st_ff.evt[1];

endmodule : cct_timer

// [pkg/cct_pkg.sv]
// Purpose: Shared constants for the capture/compare timer
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Offsets are byte addresses
package cct_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT = 8'h00;
  localparam logic [7:0] OFS_COMPARE = 8'h04;
  localparam logic [7:0] OFS_CAPMATCH = 8'h08;
  localparam logic [7:0] OFS_EVFLAGS = 8'h0C;
  localparam logic [7:0] OFS_PRICTRL = 8'h10;
  localparam logic [7:0] OFS_DEADTIME = 8'h14;
  localparam logic [7:0] OFS_SECCTRL = 8'h18;
  localparam logic [7:0] OFS_WAKEUP = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FL_IRQ_A = 0;
  localparam int FL_WRDONE_A = 8;
  localparam int FL_WRDIS_A = 9;
  localparam int FL_IRQ_B = 16;
  localparam int FL_WRDONE_B = 24;
  localparam int FL_WRDIS_B = 25;
  localparam int PC_MODE_A_LO = 0;
  localparam int PC_POL_A = 8;
  localparam int PC_RST_A = 13;
  localparam int PC_CLKEN_A = 14;
  localparam int PC_EN_A = 15;
  localparam int PC_MODE_B_LO = 16;
  localparam int PC_RST_B = 29;
  localparam int PC_CLKEN_B = 30;
  localparam int PC_EN_B = 31;
  localparam int SC_CASCADE = 31;

  // Reset values, writable masks, reload value and response codes
  localparam logic [31:0] PRICTRL_RST = 32'h0000_1000;
  localparam logic [31:0] PRICTRL_WMASK = 32'hE0FF_FFFF;
  localparam logic [31:0] SECCTRL_WMASK = 32'h9FF7_7FF7;
  localparam logic [31:0] WAKEUP_WMASK = 32'h0001_0001;
  localparam logic [31:0] RELOAD_VAL = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode codes
  typedef enum logic [3:0] {
    MODE_CAPCMP = 4'h7,
    MODE_DUALEDGE = 4'h8,
    MODE_GATED = 4'h6,
    MODE_INACT_GATED = 4'hE
  } cct_mode_t;
endpackage : cct_pkg

// [test/cct_timer_properties.sv]
// Purpose: Bus and handshake checks on the timer ports
// Assumes: One clock domain, reset active high
// Notes: Bound into every cct_timer instance
`timescale 1ns/1ps
module cct_timer_properties #(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready
);
  logic [ADDR_W-1:0] aw_ff;
  logic [ADDR_W-1:0] ar_ff;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ------------------------------------------------------------
  // Address tracking
  // ------------------------------------------------------------
  // Remember addresses so responses can be tied to them
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset) aw_ff <= '0;
    else if (i_awvalid && o_awready) aw_ff <= i_awaddr;
    if (i_reset) ar_ff <= '0;
    else if (i_arvalid && o_arready) ar_ff <= i_araddr;
  end
  function automatic logic bad(input logic [ADDR_W-1:0] a);
    return (32'(a) >= 32'h20) || (a[1:0] != 2'h0);
  endfunction : bad
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence
  sequence s_rd_done;
    o_rvalid && i_rready;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:3] o_bvalid)
    else $error("write response late");
  AST_WR_RESP: assert property ($rose(o_bvalid) |->
    o_bresp == (bad(aw_ff) ? cct_pkg::RESP_SLVERR : cct_pkg::RESP_OKAY))
    else $error("write response code wrong");
  AST_RD_ANSWER: assert property (s_rd_taken |=> o_rvalid)
    else $error("read data late");
  AST_RD_RESP: assert property ($rose(o_rvalid) |->
    o_rresp == (bad(ar_ff) ? cct_pkg::RESP_SLVERR : cct_pkg::RESP_OKAY))
    else $error("read response code wrong");
  AST_RD_ZERO: assert property (o_rvalid && o_rresp == cct_pkg::RESP_SLVERR |-> o_rdata == 0)
    else $error("unmapped read data not zero");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  AST_ONE_READ: assert property (s_rd_taken |=> !o_arready until_with s_rd_done)
    else $error("second read accepted");
  AST_B_EXCL: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while answering");
endmodule : cct_timer_properties

bind cct_timer cct_timer_properties #(.ADDR_W(ADDR_W)) u_props (
  .i_clk, .i_reset, .i_awaddr, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
  .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
  .o_rdata, .o_rresp, .o_rvalid, .i_rready
);

// [test/cct_pin_model.sv]
// Purpose: External signal on the timer input pin
// Assumes: Edges spaced well above the synchroniser delay
// Notes: Single-edge mode returns to the inactive level midway
`timescale 1ns/1ps
module cct_pin_model (
  input wire logic i_clk,
  output logic o_pin
);
  initial o_pin = 1'b0;
  // Idle level so a reset never sees a stray active edge
  task automatic park(input logic lvl);
    @(posedge i_clk);
    o_pin <= lvl;
  endtask : park
  // Next active edge exactly n cycles after the previous one
  task automatic edge_after(input int n, input logic lvl, input logic dual);
    int h;
    h = n / 2;
    if (!dual)
    begin
      repeat (h) @(posedge i_clk);
      o_pin <= !lvl;
      n = n - h;
    end
    repeat (n) @(posedge i_clk);
    o_pin <= dual ? !o_pin : lvl;
  endtask : edge_after
endmodule : cct_pin_model

// [test/cct_timer_tb_top.sv]
// Purpose: Self-checking bench for the capture/compare timer
// Assumes: AXI4-Lite master here, pin model on the timer input
// Notes: Capture gaps are random from a fixed seed
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %0t: got %0h want %0h", $time, (a), (e)); end end
`define RC(a, e) begin rd(a); `CHK(rdv, e) end
module cct_timer_tb_top;
  logic i_clk, i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_timer_in;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rdv;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_event_a, o_event_b;
  int n_mismatch = 0;
  int comparisons = 0;
  int ev_n = 0;
  int ev_b = 0;
  int unsigned gaps[$];
  logic [31:0] rst_tbl[8] = '{0, 0, 0, 32'h0100_0100, cct_pkg::PRICTRL_RST, 0, 0, 0};
  cct_timer DUT (
    .i_clk, .i_reset, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_timer_in,
    .o_event_a, .o_event_b
  );
  cct_pin_model PIN (.i_clk(i_clk), .o_pin(i_timer_in));
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Event pulses, counted to catch extra or missing ones
  always @(posedge i_clk) if (o_event_a === 1'b1) ev_n++;
  // Half B never runs in these scenarios, so any pulse there is wrong
  always @(posedge i_clk) if (o_event_b !== 1'b0) ev_b++;
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a >= 8'h20 || a[1:0] != 2'h0) ? cct_pkg::RESP_SLVERR : cct_pkg::RESP_OKAY;
  endfunction : resp_of
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    forever
    begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid)
      begin
        i_bready <= 1'b0;
        `CHK(o_bresp, resp_of(a))
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    forever
    begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid)
      begin
        i_rready <= 1'b0;
        rdv = o_rdata;
        `CHK(o_rresp, resp_of(a))
        break;
      end
    end
  endtask : rd
  task automatic reset_dut();
    i_reset <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
  endtask : reset_dut
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic tbl();
    for (int k = 0; k < 8; k++)
      `RC(8'(4 * k), rst_tbl[k])
  endtask : tbl
  // Dual halves: write protect and cascade read-back
  task automatic half_run();
    wr(cct_pkg::OFS_PRICTRL, 32'h4000_4000);
    wr(cct_pkg::OFS_COUNT, 32'hFFFF_FFFF);
    `RC(cct_pkg::OFS_COUNT, 32'h0000_FFFF)
    wr(cct_pkg::OFS_EVFLAGS, 32'h0200_0200);
    `RC(cct_pkg::OFS_EVFLAGS, 32'h0300_0300)
    wr(cct_pkg::OFS_COUNT, 32'h1234_5678);
    `RC(cct_pkg::OFS_COUNT, 32'h1234_FFFF)
    wr(cct_pkg::OFS_SECCTRL, 32'h8000_0000);
    `RC(cct_pkg::OFS_EVFLAGS, 32'h0100_0100)
  endtask : half_run
  // Start edge, then two captures spaced g cycles apart
  task automatic cap_run(input logic [3:0] md, input logic pl, input logic du);
    int unsigned g, a;
    logic [31:0] init, ctl;
    g = 16 + $urandom % 100;
    init = $urandom % 256;
    ctl = 32'h4000 | 32'(md) | (32'(pl) << 8);
    PIN.park(!pl);
    reset_dut();
    `RC(cct_pkg::OFS_COUNT, 32'h0)
    wr(cct_pkg::OFS_COUNT, 32'h55);
    wr(cct_pkg::OFS_CAPMATCH, 32'h55);
    `RC(cct_pkg::OFS_COUNT, 32'h0)
    `RC(cct_pkg::OFS_CAPMATCH, 32'h0)
    wr(cct_pkg::OFS_SECCTRL, 32'h8000_0000);
    wr(cct_pkg::OFS_COMPARE, 32'hFFF);
    wr(cct_pkg::OFS_PRICTRL, ctl);
    wr(cct_pkg::OFS_COUNT, init);
    wr(cct_pkg::OFS_PRICTRL, ctl | 32'h8000);
    for (int k = 0; k < 10 && rdv[15] !== 1'b1; k++) rd(cct_pkg::OFS_PRICTRL);
    `CHK(rdv[15], 1'b1)
    repeat (20) @(posedge i_clk);
    `RC(cct_pkg::OFS_COUNT, init)
    ev_n = 0;
    PIN.edge_after(10, pl, du);
    repeat (8) @(posedge i_clk);
    `RC(cct_pkg::OFS_EVFLAGS, 32'h0100_0100)
    a = rdv;
    rd(cct_pkg::OFS_COUNT);
    a = rdv;
    rd(cct_pkg::OFS_COUNT);
    `CHK(rdv > a, 1'b1)
    gaps.push_back(g);
    PIN.edge_after(g, pl, du);
    PIN.edge_after(g, pl, du);
    repeat (6) @(posedge i_clk);
    `CHK(ev_n, 2)
    a = gaps.pop_front();
    `RC(cct_pkg::OFS_CAPMATCH, a)
    `RC(cct_pkg::OFS_EVFLAGS, 32'h0100_0101)
    wr(cct_pkg::OFS_EVFLAGS, 32'h0);
    `RC(cct_pkg::OFS_EVFLAGS, 32'h0100_0101)
    wr(cct_pkg::OFS_EVFLAGS, 32'h1);
    `RC(cct_pkg::OFS_EVFLAGS, 32'h0100_0100)
  endtask : cap_run
  // No captures: period of c cycles from compare match
  task automatic cmp_run();
    int c, n;
    c = 8 + $urandom % 40;
    n = 0;
    PIN.park(1'b0);
    reset_dut();
    wr(cct_pkg::OFS_SECCTRL, 32'h8000_0000);
    wr(cct_pkg::OFS_COMPARE, c);
    wr(cct_pkg::OFS_PRICTRL, 32'hC107);
    PIN.edge_after(10, 1'b1, 1'b0);
    for (int k = 0; k < 200 && o_event_a !== 1'b1; k++) @(posedge i_clk);
    for (int k = 0; k < 200; k++)
    begin
      @(posedge i_clk);
      n++;
      if (o_event_a === 1'b1) break;
    end
    `CHK(n, c)
  endtask : cmp_run
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Watchdog: far beyond the expected run of about a thousand cycles
  initial
  begin
    #500000;
    n_mismatch++;
    results();
  end
  initial
  begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_awaddr, i_araddr, i_wdata} = '0;
    i_wstrb = 4'hF;
    i_reset = 1'b1;
    rdv = '0;
    void'($urandom(32'h250A));
    reset_dut();
    tbl();
    `RC(8'h20, 32'h0)
    `RC(8'h02, 32'h0)
    wr(8'h24, 32'hFFFF_FFFF);
    half_run();
    cap_run(4'h7, 1'b1, 1'b0);
    cap_run(4'h7, 1'b0, 1'b0);
    cap_run(4'h8, 1'b1, 1'b1);
    cmp_run();
    // Inactive gated: pin high gives no events, pin low gives them
    wr(cct_pkg::OFS_PRICTRL, 32'hC10E);
    repeat (2) @(posedge i_clk);
    ev_n = 0;
    repeat (8) @(posedge i_clk);
    `CHK(ev_n, 0)
    PIN.park(1'b0);
    repeat (8) @(posedge i_clk);
    `CHK(ev_n >= 4, 1'b1)
    wr(cct_pkg::OFS_DEADTIME, 32'hAB);
    reset_dut();
    tbl();
    `CHK(ev_b, 0)
    results();
  end
endmodule : cct_timer_tb_top
